// *** include/wpd_defines.svh ***
// Constants of the wake pin detector
`ifndef WPD_DEFINES_SVH
`define WPD_DEFINES_SVH
// Filter time window in ns and clock period in ns
`define WPD_FILT_MIN_NS   10000
`define WPD_FILT_MAX_NS   25000
`define WPD_CLK_PERIOD_NS 4
// Filter count: at least the minimum time, rounded up
`define WPD_FILT_CYCLES   ((`WPD_FILT_MIN_NS + `WPD_CLK_PERIOD_NS - 1) / `WPD_CLK_PERIOD_NS)
`define WPD_RST_LEVEL     1'b0
// Pad output enable after reset: high, so the pin is never driven
`define WPD_PAD_OE_N_RST  1'b1
`endif

// *** include/wpd_pkg.sv ***
// Types of the wake pin detector
package wpd_pkg;
   typedef enum logic [2:0] {
      WPD_MODE_OFF,
      WPD_MODE_NORMAL,
      WPD_MODE_STOP,
      WPD_MODE_FLASH,
      WPD_MODE_SLEEP,
      WPD_MODE_FAILSAFE,
      WPD_MODE_OTHER
   } wpd_mode_type;

   typedef struct packed {
      logic rise;
      logic fall;
   } wpd_edge_type;
endpackage

// *** logic/wpd_detector.sv ***
// Wake pin detector: synchroniser, filter, edge flags, mode requests
`timescale 1ns/10ps
`include "wpd_defines.svh"
// Behaviour
// [R1] Both edge directions count as wake events
// [R2] Accept level only after filter time
// [R3] Software enable gates wake capability
// [R4] OFF mode: pin undriven, events ignored
// [R5] Level readable in Normal, Stop, Flash
// [R6] Enabled filtered edge leaves Sleep
// [R7] Fail-Safe edge always requests Restart
// [R8] Enabled active modes set edge flags, interrupt
// [R9] Rise and fall interrupts masked separately
// [R10] Refuse Normal-to-Sleep while flags set
// [R11] Pending flag wakes right after Sleep entry
// [R12] Controller clears flags before Sleep command
// [R13] Synchronise input before filtering
module wpd_detector #(
   parameter int FILT_CYCLES = `WPD_FILT_CYCLES
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Wake pin
   input  wire logic              wake_input,
   output logic                   wake_pad_oe_n,
   // Mode and control
   input  wire wpd_pkg::wpd_mode_type mode,
   input  wire logic              wake_pin_enable,
   input  wire wpd_pkg::wpd_edge_type irq_mask,
   input  wire wpd_pkg::wpd_edge_type flag_clear,
   input  wire logic              sleep_cmd,
   // Status and requests
   output logic                   wake_level_status,
   output logic                   wake_rise_flag,
   output logic                   wake_fall_flag,
   output logic                   wake_irq,
   output logic                   wakeup_req,
   output logic                   restart_req,
   output logic                   sleep_grant,
   output logic                   sleep_refused
);
   import wpd_pkg::*;

   // ****************************************
   // Parameters and checks
   // ****************************************
   localparam int CW = $clog2(FILT_CYCLES + 1);

   // A count beyond the window cannot meet the filter time, so it stops elaboration
   if (FILT_CYCLES < 1 || FILT_CYCLES * `WPD_CLK_PERIOD_NS > `WPD_FILT_MAX_NS) begin : g_filt_bad
      $error("FILT_CYCLES outside the filter window");
   end

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic          sync1;
      logic          sync2;
      logic          filt;
      logic [CW-1:0] cnt;
      logic          level;
      logic          rise_f;
      logic          fall_f;
      logic          irq;
      logic          wake;
      logic          rst_rq;
      logic          grant;
      logic          refused;
      logic          pad_oe_n;
   } wpd_state_type;

   // Pad stays undriven from reset on; the filtered level starts low
   localparam wpd_state_type ST_RST = '{pad_oe_n: `WPD_PAD_OE_N_RST, filt: `WPD_RST_LEVEL, default: '0};

   wpd_state_type st_r;
   wpd_state_type st_nxt;

   logic ev_rise;
   logic ev_fall;
   logic pw_on;
   logic active;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      // Input-only pin: the pad is never driven, in any mode
      st_nxt.pad_oe_n = 1'b1;   // [R4]
      pw_on  = (mode != WPD_MODE_OFF);
      active = (mode == WPD_MODE_NORMAL) || (mode == WPD_MODE_STOP) || (mode == WPD_MODE_FLASH);
      // Two stages; only the second stage is looked at
      st_nxt.sync1 = wake_input;   // [R13]
      st_nxt.sync2 = st_r.sync1;   // [R13]
      ev_rise = 1'b0;
      ev_fall = 1'b0;
      // Counter restarts on every bounce of the synchronised level
      if (!pw_on || st_r.sync2 == st_r.filt) begin   // [R4]
         st_nxt.cnt = '0;
      end else if (st_r.cnt == CW'(FILT_CYCLES - 1)) begin   // [R2]
         st_nxt.cnt  = '0;
         st_nxt.filt = st_r.sync2;
         ev_rise     = st_r.sync2;    // [R1]
         ev_fall     = !st_r.sync2;   // [R1]
      end else begin
         st_nxt.cnt = st_r.cnt + CW'(1);
      end
      if (active) begin
         st_nxt.level = st_r.filt;   // [R5]
      end
      // Set wins over clear
      if (flag_clear.rise) st_nxt.rise_f = 1'b0;
      if (flag_clear.fall) st_nxt.fall_f = 1'b0;
      if (!pw_on) begin   // [R4]
         st_nxt.rise_f = 1'b0;
         st_nxt.fall_f = 1'b0;
      end
      if (active && wake_pin_enable && ev_rise) st_nxt.rise_f = 1'b1;   // [R8] [R3]
      if (active && wake_pin_enable && ev_fall) st_nxt.fall_f = 1'b1;   // [R8] [R3]
      st_nxt.irq = (st_nxt.rise_f && !irq_mask.rise) || (st_nxt.fall_f && !irq_mask.fall);   // [R9]
      // Sleep wake on a new edge or a left-over flag
      st_nxt.wake = (mode == WPD_MODE_SLEEP) &&
                    ((wake_pin_enable && (ev_rise || ev_fall)) || st_r.rise_f || st_r.fall_f);   // [R6] [R11]
      st_nxt.rst_rq  = (mode == WPD_MODE_FAILSAFE) && (ev_rise || ev_fall);   // [R7]
      st_nxt.grant   = sleep_cmd && (mode == WPD_MODE_NORMAL) && !st_r.rise_f && !st_r.fall_f;   // [R10] [R12]
      st_nxt.refused = sleep_cmd && (mode == WPD_MODE_NORMAL) && (st_r.rise_f || st_r.fall_f);    // [R10]
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Each output is a register field, so no pin sees a combinational glitch
   assign wake_pad_oe_n     = st_r.pad_oe_n;   // [R4]
   assign wake_level_status = st_r.level;
   assign wake_rise_flag    = st_r.rise_f;
   assign wake_fall_flag    = st_r.fall_f;
   assign wake_irq          = st_r.irq;
   assign wakeup_req        = st_r.wake;
   assign restart_req       = st_r.rst_rq;
   assign sleep_grant       = st_r.grant;
   assign sleep_refused     = st_r.refused;

   // ****************************************
   // Assertions
   // ****************************************
   logic flt_chg;
   assign flt_chg = st_nxt.filt != st_r.filt;

   // Filter: a change needs a run of the new level, and the count never skips a step
   no_short_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R2]
      $changed(st_r.filt) |-> $past(st_r.sync2 != st_r.filt, 2))
      else $error("filter passed early");
   cnt_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R2]
      (pw_on && st_r.sync2 != st_r.filt && st_r.cnt != CW'(FILT_CYCLES - 1)) |=>
      st_r.cnt == $past(st_r.cnt) + CW'(1)) else $error("filter count skipped");
   filt_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R2]
      (pw_on && st_r.sync2 != st_r.filt && st_r.cnt == CW'(FILT_CYCLES - 1)) |=> st_r.filt == $past(st_r.sync2))
      else $error("filter stuck");
   rise_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R8]
      (active && wake_pin_enable && ev_rise) |=> wake_rise_flag)
      else $error("rise flag missed");
   fall_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R8]
      (active && wake_pin_enable && ev_fall) |=> wake_fall_flag)
      else $error("fall flag missed");
   no_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R3]
      (!wake_pin_enable && !wake_rise_flag && mode != WPD_MODE_SLEEP) |=> !wake_rise_flag || $past(wake_pin_enable))
      else $error("flag without enable");
   off_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R4]
      (mode == WPD_MODE_OFF) |=> !wake_rise_flag && !wake_fall_flag && !restart_req)
      else $error("event in off");
   irq_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R9]
      wake_irq |-> (wake_rise_flag && !$past(irq_mask.rise)) || (wake_fall_flag && !$past(irq_mask.fall)))
      else $error("masked irq");
   irq_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R8]
      ((wake_rise_flag && !$past(irq_mask.rise)) || (wake_fall_flag && !$past(irq_mask.fall))) |-> wake_irq)
      else $error("unmasked flag without irq");
   failsafe_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R7]
      (mode == WPD_MODE_FAILSAFE && (ev_rise || ev_fall)) |=> restart_req)
      else $error("no restart");
   restart_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R7]
      (mode != WPD_MODE_FAILSAFE) |=> !restart_req)
      else $error("restart outside fail-safe");
   sleep_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R11]
      (mode == WPD_MODE_SLEEP && (wake_rise_flag || wake_fall_flag)) |=> wakeup_req)
      else $error("no sleep wake");
   sleep_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R6]
      (mode == WPD_MODE_SLEEP && wake_pin_enable && (ev_rise || ev_fall)) |=> wakeup_req)
      else $error("edge no wake");
   refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R10]
      (sleep_cmd && mode == WPD_MODE_NORMAL && (wake_rise_flag || wake_fall_flag)) |=> sleep_refused && !sleep_grant)
      else $error("sleep not refused");
   grant_ok_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R10]
      (sleep_cmd && mode == WPD_MODE_NORMAL && !wake_rise_flag && !wake_fall_flag) |=> sleep_grant && !sleep_refused)
      else $error("clean sleep not granted");
   no_grant_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R10]
      !(sleep_cmd && mode == WPD_MODE_NORMAL) |=> !sleep_grant && !sleep_refused)
      else $error("sleep answer without command");
   level_a: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [R5]
      active |=> wake_level_status == $past(st_r.filt))
      else $error("level wrong");

   // ****************************************
   // Coverage
   // ****************************************
   rise_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(wake_rise_flag));
   fall_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(wake_fall_flag));
   wake_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(wakeup_req));
   refuse_c: cover property (@(posedge clk_sys) disable iff (!rst_n) sleep_refused);
   filt_c: cover property (@(posedge clk_sys) disable iff (!rst_n) flt_chg);
endmodule // wpd_detector

// *** test/wpd_wake_switch.sv ***
// Wake switch model that drives the wake pin
`timescale 1ns/10ps
// ****
// Switch with contact bounce
// ****
module wpd_wake_switch (
   // Commanded level and bounce
   input  wire logic level_cmd,
   input  wire logic bounce,
   // Pin
   output logic      wake_input
);
   // Always driven; bounce inverts the commanded level while it is high
   assign wake_input = level_cmd ^ bounce;
endmodule // wpd_wake_switch

// *** test/wake_pin_detector_tb_top.sv ***
// Self-checking bench of the wake pin detector
`timescale 1ns/10ps
module wake_pin_detector_tb_top;
   import wpd_pkg::*;
   typedef struct packed {
      wpd_mode_type m;
      logic         en;
      wpd_edge_type mk;
      logic         lv;
      logic [3:0]   ex;
   } wpd_row_type;
   // ****
   // Signals
   // ****
   logic         clk_sys = 1'b0;
   logic         rst_n = 1'b0;
   logic         lvl = 1'b0;
   logic         bnc = 1'b0;
   logic         en = 1'b0;
   logic         cmd = 1'b0;
   logic         hit_wk = 1'b0;
   logic         hit_rs = 1'b0;
   logic         pin, oe_n, lvs, rf, ff, irq, wk, rs, sg, sr;
   wpd_mode_type md = WPD_MODE_NORMAL;
   wpd_edge_type mk = 2'h0;
   wpd_edge_type clr = 2'h0;
   int           bad_count = 0;
   int           n_compared = 0;
   int           cyc = 0;
   // Flags: {rise, fall, irq, level status}
   wpd_row_type  rows [5] = '{'{WPD_MODE_NORMAL, 1'b1, 2'h0, 1'b1, 4'hB},
                             '{WPD_MODE_NORMAL, 1'b1, 2'h2, 1'b0, 4'h6},
                             '{WPD_MODE_STOP, 1'b1, 2'h2, 1'b1, 4'h9},
                             '{WPD_MODE_FLASH, 1'b0, 2'h0, 1'b0, 4'h0},
                             '{WPD_MODE_OFF, 1'b1, 2'h0, 1'b1, 4'h0}};
   wpd_wake_switch sw (.level_cmd(lvl), .bounce(bnc), .wake_input(pin));
   // Short filter keeps each wait near a dozen cycles
   wpd_detector #(.FILT_CYCLES(4)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .wake_input(pin),
      .wake_pad_oe_n(oe_n), .mode(md), .wake_pin_enable(en), .irq_mask(mk), .flag_clear(clr),
      .sleep_cmd(cmd), .wake_level_status(lvs), .wake_rise_flag(rf), .wake_fall_flag(ff),
      .wake_irq(irq), .wakeup_req(wk), .restart_req(rs), .sleep_grant(sg), .sleep_refused(sr));
   initial forever #2 clk_sys = ~clk_sys;
   // One-cycle requests are caught here so the checks need not hit the exact cycle
   always @(posedge clk_sys) begin
      cyc++;
      if (wk) hit_wk = 1'b1;
      if (rs) hit_rs = 1'b1;
      if (cyc == 2000) begin
         bad_count++;
         close_out();
      end
   end
   // ****
   // Tasks
   // ****
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic nc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic clear();
      clr = 2'h3;
      nc(1);
      clr = 2'h0;
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ****
   // Stimulus
   // ****
   initial begin
      nc(3);
      chk({rf, ff, irq, oe_n}, 4'h1);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         md = rows[i].m;
         en = rows[i].en;
         mk = rows[i].mk;
         lvl = rows[i].lv;
         nc(12);
         chk({rf, ff, irq, lvs}, rows[i].ex);
         clear();
      end
      md = WPD_MODE_NORMAL;
      nc(12);
      clear();
      bnc = 1'b1;
      nc(2);
      bnc = 1'b0;
      nc(12);
      chk({rf, ff, irq, lvs}, 4'h1);
      lvl = 1'b0;
      nc(12);
      cmd = 1'b1;
      nc(1);
      chk({ff, sr, sg, 1'b0}, 4'hC);
      cmd = 1'b0;
      md = WPD_MODE_SLEEP;
      en = 1'b0;
      nc(3);
      chk({hit_wk, 3'h0}, 4'h8);
      md = WPD_MODE_NORMAL;
      en = 1'b1;
      clear();
      cmd = 1'b1;
      nc(1);
      chk({sr, sg, 2'h0}, 4'h4);
      cmd = 1'b0;
      md = WPD_MODE_SLEEP;
      nc(3);
      hit_wk = 1'b0;
      lvl = 1'b1;
      nc(12);
      chk({hit_wk, 3'h0}, 4'h8);
      md = WPD_MODE_FAILSAFE;
      nc(3);
      hit_rs = 1'b0;
      lvl = 1'b0;
      nc(12);
      chk({hit_rs, 3'h0}, 4'h8);
      // Sleep with the enable off and no flags must stay asleep
      md = WPD_MODE_SLEEP;
      en = 1'b0;
      nc(3);
      hit_wk = 1'b0;
      hit_rs = 1'b0;
      lvl = 1'b1;
      nc(12);
      chk({hit_wk, hit_rs, 2'h0}, 4'h0);
      // Mid-run reset clears flags and requests; a high pin then reads as a rise
      md = WPD_MODE_NORMAL;
      en = 1'b1;
      lvl = 1'b0;
      nc(12);
      rst_n = 1'b0;
      lvl = 1'b1;
      nc(3);
      chk({rf, ff, irq, oe_n}, 4'h1);
      chk({lvs, wk, rs, sg | sr}, 4'h0);
      rst_n = 1'b1;
      nc(12);
      chk({rf, ff, irq, lvs}, 4'hB);
      close_out();
   end
endmodule // wake_pin_detector_tb_top
